// >>> core/rs_fec_pkg.sv
// package: widths, register offsets, field positions, reset values and
// thresholds for the fec mode control and status block
// assumes a single 20 MHz clock and an axi4-lite register port
package rs_fec_pkg;
  localparam int          CLK_PERIOD_NS  = 50;        // clock_i period
  localparam int          DATA_W         = 64;        // transceiver word width
  localparam int          ADDR_W         = 8;         // register byte address width
  localparam int          FRAC_W         = 7;         // deskew fraction, 1/66 cycle units
  localparam int          FILL_W         = 14;        // cycles in [13:7], fraction in [6:0]
  localparam int          SERR_W         = 4;         // symbol errors per codeword input
  localparam int          SCNT_W         = 17;        // window symbol error accumulator
  localparam int          WIN_W          = 13;        // codeword index within a window
  localparam logic [12:0] WIN_LAST       = 13'h1FFF;  // 8192 codewords per window
  localparam logic [16:0] SER_LIMIT      = 17'h001A1; // 417 errors, flag when above
  localparam int          IRQ_W          = 4;         // interrupt event count
  localparam int          MARKER_SPACING = 20480;     // words between alignment markers
  // register byte offsets
  localparam logic [7:0]  MODE_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS       = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFS   = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h0C;
  localparam logic [7:0]  SER_CNT_OFS    = 8'h10;
  localparam logic [7:0]  LANE0_FILL_OFS = 8'h14;
  localparam logic [7:0]  LANE1_FILL_OFS = 8'h18;
  // interrupt bit positions
  localparam int          IRQ_HI_SER     = 0;
  localparam int          IRQ_UNFIXABLE  = 1;
  localparam int          IRQ_LOCK_LOST  = 2;
  localparam int          IRQ_ALIGNED    = 3;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;      // all events masked after reset
  // axi response codes
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// >>> core/rs_fec_lane_status.sv
// one receive lane: alignment marker lock and deskew delay report
// assumes lock and delay inputs come from the lane aligner on clock_i
`timescale 1ns/10ps
module rs_fec_lane_status (
  input  wire logic                            clock_i,
  input  wire logic                            rstn_i,
  input  wire logic                            lock_i,       // aligner lock level
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]   cycles_i,     // whole deskew cycles
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]   frac_i,       // 1/66 cycle units
  output logic                                 lock_o,       // registered lock
  output logic [rs_fec_pkg::FILL_W-1:0]        fill_o,       // packed delay
  output logic                                 lock_lost_o   // one-cycle pulse
);
  import rs_fec_pkg::*;

  logic                 lock_ff;   // lock as reported
  logic [FILL_W-1:0]    fill_ff;   // delay as reported
  logic                 lost_ff;   // falling lock edge
  logic [FILL_W-1:0]    nxt_fill;  // cycles above, fraction below

  assign nxt_fill = {cycles_i, frac_i};

  // register lock and delay; lost pulse marks a drop of lock
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      lock_ff <= 1'b0;
      fill_ff <= '0;
      lost_ff <= 1'b0;
    end else begin
      lock_ff <= lock_i;
      fill_ff <= nxt_fill;
      lost_ff <= lock_ff & ~lock_i;
    end
  end

  assign lock_o      = lock_ff;
  assign fill_o      = fill_ff;
  assign lock_lost_o = lost_ff;
endmodule // rs_fec_lane_status

// >>> core/rs_fec_mode_control_status.sv
// fec stage mode control, datapath bypass, lock/alignment status,
// symbol error rate monitor and axi4-lite register port with interrupt
// assumes all inputs synchronous to clock_i; encoder/decoder lie outside
`timescale 1ns/10ps

module rs_fec_mode_control_status (
  input  wire logic                               clock_i,
  input  wire logic                               rstn_i,
  // mode controls, caught once after reset
  input  wire logic                               fec_enable_i,
  input  wire logic                               correction_enable_i,
  input  wire logic                               indication_enable_i,
  input  wire logic                               ieee_mode_i,
  // transmit datapath
  input  wire logic [rs_fec_pkg::DATA_W-1:0]      pcs_tx_data_i,
  input  wire logic [rs_fec_pkg::DATA_W-1:0]      fec_tx_data_i,
  output logic [rs_fec_pkg::DATA_W-1:0]           serdes_tx_data_o,
  // transmit status
  input  wire logic                               tx_block_lock_i,
  input  wire logic                               tx_frame_aligned_i,
  output logic                                    tx_block_lock_o,
  output logic                                    tx_frame_aligned_o,
  // receive lanes
  input  wire logic                               rx_lane0_lock_i,
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]      rx_lane0_cycles_i,
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]      rx_lane0_frac_i,
  input  wire logic                               rx_lane1_lock_i,
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]      rx_lane1_cycles_i,
  input  wire logic [rs_fec_pkg::FRAC_W-1:0]      rx_lane1_frac_i,
  input  wire logic                               rx_deskew_done_i,
  output logic                                    rx_marker_lock_lane0_o,
  output logic                                    rx_marker_lock_lane1_o,
  output logic [rs_fec_pkg::FILL_W-1:0]           rx_lane_fill0_o,
  output logic [rs_fec_pkg::FILL_W-1:0]           rx_lane_fill1_o,
  output logic                                    rx_lanes_aligned_o,
  // decoder results, one per codeword
  input  wire logic                               cw_done_i,
  input  wire logic                               cw_uncorrectable_i,
  input  wire logic [rs_fec_pkg::SERR_W-1:0]      cw_symbol_errors_i,
  output logic                                    fixed_codeword_pulse_o,
  output logic                                    unfixable_codeword_pulse_o,
  output logic                                    pcs_error_mark_o,
  output logic                                    high_symbol_error_out_o,
  // decoder mode outputs
  output logic                                    fec_inserted_o,
  output logic                                    correction_on_o,
  output logic                                    indication_on_o,
  output logic                                    decoder_bypass_o,
  // axi4-lite slave
  input  wire logic [rs_fec_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [rs_fec_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic                                    irq_o
);
  import rs_fec_pkg::*;

  // captured mode
  logic              armed_ff;     // high until the post-reset sample
  logic              fec_en_ff;    // fec inserted
  logic              corr_en_ff;   // correction enable
  logic              ind_en_ff;    // indication enable
  logic              ieee_ff;      // standard indication mode
  // derived mode
  logic              dec_bypass;   // decoder fully bypassed
  logic              dec_active;   // decoder looks at codewords
  logic              corr_on;      // errors are corrected
  logic              ind_on;       // uncorrectable marked to pcs
  logic              ser_mode;     // indication bypass with correction
  // datapath and status flops
  logic [DATA_W-1:0] tx_data_ff;
  logic              tx_lock_ff;
  logic              tx_align_ff;
  logic              rx_align_ff;
  logic              fixed_ff;
  logic              unfix_ff;
  logic              mark_ff;
  // symbol error monitor
  logic [WIN_W-1:0]  win_ff;       // codeword index in window
  logic [SCNT_W-1:0] serr_ff;      // errors in current window
  logic              hi_ser_ff;    // high symbol error flag
  logic [SCNT_W-1:0] nxt_serr;
  logic              win_end;
  logic              over_limit;
  // lanes
  logic              lock0, lock1, lost0, lost1;
  logic [FILL_W-1:0] fill0, fill1;
  logic              nxt_aligned;
  // interrupts
  logic [IRQ_W-1:0]  irq_stat_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [IRQ_W-1:0]  irq_event;
  logic [IRQ_W-1:0]  irq_clear;
  // axi write side
  logic              aw_got_ff, w_got_ff, bvalid_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic [1:0]        bresp_ff;
  logic              do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit_mask, wr_hit_stat, wr_hit_ro, wr_mapped;
  // axi read side
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              rd_take;
  logic [31:0]       rd_word;
  logic              rd_mapped;

  // catch the four controls once; later changes wait for a reset
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      armed_ff   <= 1'b1;
      fec_en_ff  <= 1'b0;
      corr_en_ff <= 1'b0;
      ind_en_ff  <= 1'b0;
      ieee_ff    <= 1'b0;
    end else if (armed_ff) begin
      armed_ff   <= 1'b0;
      fec_en_ff  <= fec_enable_i;
      corr_en_ff <= correction_enable_i;
      ind_en_ff  <= indication_enable_i;
      ieee_ff    <= ieee_mode_i;
    end
  end

  // mode decode
  assign dec_bypass = fec_en_ff & ~ieee_ff & ~corr_en_ff & ~ind_en_ff;
  assign dec_active = fec_en_ff & ~dec_bypass;
  assign corr_on    = dec_active & corr_en_ff;
  assign ind_on     = dec_active & ind_en_ff;
  assign ser_mode   = corr_on & ~ind_en_ff;

  assign fec_inserted_o   = fec_en_ff;
  assign correction_on_o  = corr_on;
  assign indication_on_o  = ind_on;
  assign decoder_bypass_o = dec_bypass;

  // transmit path: bypass skips the encoder and its pipeline entirely
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_data_ff <= '0;
    end else begin
      tx_data_ff <= fec_en_ff ? fec_tx_data_i : pcs_tx_data_i;
    end
  end
  assign serdes_tx_data_o = tx_data_ff;

  // lane status, one instance per receive lane
  rs_fec_lane_status u_lane0 (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .lock_i      (rx_lane0_lock_i),
    .cycles_i    (rx_lane0_cycles_i),
    .frac_i      (rx_lane0_frac_i),
    .lock_o      (lock0),
    .fill_o      (fill0),
    .lock_lost_o (lost0)
  );
  rs_fec_lane_status u_lane1 (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .lock_i      (rx_lane1_lock_i),
    .cycles_i    (rx_lane1_cycles_i),
    .frac_i      (rx_lane1_frac_i),
    .lock_o      (lock1),
    .fill_o      (fill1),
    .lock_lost_o (lost1)
  );
  assign rx_marker_lock_lane0_o = lock0;
  assign rx_marker_lock_lane1_o = lock1;
  assign rx_lane_fill0_o        = fill0;
  assign rx_lane_fill1_o        = fill1;

  // aligned only when both registered lane locks and deskew agree
  assign nxt_aligned = lock0 & lock1 & rx_deskew_done_i;

  // status flops for transmit lock/alignment and receive alignment
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_lock_ff  <= 1'b0;
      tx_align_ff <= 1'b0;
      rx_align_ff <= 1'b0;
    end else begin
      tx_lock_ff  <= tx_block_lock_i;
      tx_align_ff <= tx_frame_aligned_i;
      rx_align_ff <= nxt_aligned;
    end
  end
  assign tx_block_lock_o    = tx_lock_ff;
  assign tx_frame_aligned_o = tx_align_ff;
  assign rx_lanes_aligned_o = rx_align_ff;

  // codeword pulses; with correction off any errored word stays unfixed
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fixed_ff <= 1'b0;
      unfix_ff <= 1'b0;
      mark_ff  <= 1'b0;
    end else begin
      fixed_ff <= cw_done_i & corr_on & ~cw_uncorrectable_i
                  & (cw_symbol_errors_i != '0);
      unfix_ff <= cw_done_i & dec_active & (cw_uncorrectable_i
                  | (~corr_on & (cw_symbol_errors_i != '0)));
      mark_ff  <= cw_done_i & ind_on & cw_uncorrectable_i;
    end
  end
  assign fixed_codeword_pulse_o     = fixed_ff;
  assign unfixable_codeword_pulse_o = unfix_ff;
  assign pcs_error_mark_o           = mark_ff;

  // symbol error window; accumulator is wide enough not to wrap
  assign nxt_serr   = serr_ff + SCNT_W'(cw_symbol_errors_i);
  assign win_end    = cw_done_i & (win_ff == WIN_LAST);
  assign over_limit = nxt_serr > SER_LIMIT;

  // flag rises as soon as the window passes the limit, then follows
  // each closing window; outside the monitored mode it stays low
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !ser_mode) begin
      win_ff    <= '0;
      serr_ff   <= '0;
      hi_ser_ff <= 1'b0;
    end else if (cw_done_i) begin
      win_ff    <= win_ff + WIN_W'(1);
      serr_ff   <= win_end ? '0 : nxt_serr;
      hi_ser_ff <= over_limit | (hi_ser_ff & ~win_end);
    end
  end
  assign high_symbol_error_out_o = hi_ser_ff;

  // interrupt events and write-one-to-clear; a new event beats a clear
  assign irq_event[IRQ_HI_SER]    = ser_mode & cw_done_i & over_limit & ~hi_ser_ff;
  assign irq_event[IRQ_UNFIXABLE] = unfix_ff;
  assign irq_event[IRQ_LOCK_LOST] = lost0 | lost1;
  assign irq_event[IRQ_ALIGNED]   = nxt_aligned & ~rx_align_ff;
  assign irq_clear = (do_write && wr_hit_stat && wr_strb[0]) ? wr_data[IRQ_W-1:0] : '0;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clear) | irq_event;
      if (do_write && wr_hit_mask && wr_strb[0]) begin
        irq_mask_ff <= wr_data[IRQ_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // axi write: address and data accepted in either order
  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign wr_addr  = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data  = w_got_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb  = w_got_ff ? w_strb_ff : s_axi_wstrb;
  assign do_write = ~bvalid_ff & (aw_got_ff | s_axi_awvalid) & (w_got_ff | s_axi_wvalid);
  assign wr_hit_mask = wr_addr == IRQ_MASK_OFS;
  assign wr_hit_stat = wr_addr == IRQ_STAT_OFS;
  assign wr_hit_ro   = (wr_addr == MODE_OFS) || (wr_addr == STAT_OFS)
                    || (wr_addr == SER_CNT_OFS) || (wr_addr == LANE0_FILL_OFS)
                    || (wr_addr == LANE1_FILL_OFS);
  assign wr_mapped   = wr_hit_mask | wr_hit_stat | wr_hit_ro;

  // hold whichever half came first, answer once both are in
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      bresp_ff   <= RESP_OKAY;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // axi read: one outstanding, data one cycle after the address
  assign s_axi_arready = ~rvalid_ff;
  assign rd_take       = s_axi_arvalid & ~rvalid_ff;
  assign rd_mapped     = (s_axi_araddr == MODE_OFS) || (s_axi_araddr == STAT_OFS)
                      || (s_axi_araddr == IRQ_STAT_OFS) || (s_axi_araddr == IRQ_MASK_OFS)
                      || (s_axi_araddr == SER_CNT_OFS) || (s_axi_araddr == LANE0_FILL_OFS)
                      || (s_axi_araddr == LANE1_FILL_OFS);

  // read mux; unused upper bits read as zero
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == MODE_OFS) begin
      rd_word[5:0] = {ser_mode, dec_bypass, ieee_ff, ind_en_ff, corr_en_ff, fec_en_ff};
    end else if (s_axi_araddr == STAT_OFS) begin
      rd_word[5:0] = {hi_ser_ff, rx_align_ff, lock1, lock0, tx_align_ff, tx_lock_ff};
    end else if (s_axi_araddr == IRQ_STAT_OFS) begin
      rd_word[IRQ_W-1:0] = irq_stat_ff;
    end else if (s_axi_araddr == IRQ_MASK_OFS) begin
      rd_word[IRQ_W-1:0] = irq_mask_ff;
    end else if (s_axi_araddr == SER_CNT_OFS) begin
      rd_word[SCNT_W-1:0] = serr_ff;
    end else if (s_axi_araddr == LANE0_FILL_OFS) begin
      rd_word[FILL_W-1:0] = fill0;
    end else if (s_axi_araddr == LANE1_FILL_OFS) begin
      rd_word[FILL_W-1:0] = fill1;
    end
  end

  // read answer register
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  chk_mode_held: assert property (
    (!armed_ff && !$past(armed_ff)) |-> $stable(fec_en_ff) && $stable(corr_en_ff)
  ) else $error("mode changed after capture");
  chk_bypass_route: assert property (
    (rstn_i && !fec_en_ff && !armed_ff) |=> serdes_tx_data_o == $past(pcs_tx_data_i)
  ) else $error("bypass data not straight from pcs");
  chk_fec_route: assert property (
    (rstn_i && fec_en_ff) |=> serdes_tx_data_o == $past(fec_tx_data_i)
  ) else $error("fec data not routed");
  chk_dec_bypass: assert property (
    $past(dec_bypass) |-> !(fixed_ff | unfix_ff | mark_ff)
  ) else $error("codeword pulse while decoder bypassed");
  chk_hi_ser_mode: assert property (
    !ser_mode |=> !high_symbol_error_out_o
  ) else $error("high error flag outside monitored mode");
  chk_unfix_pulse: assert property (
    (cw_done_i && cw_uncorrectable_i && dec_active) |=> unfixable_codeword_pulse_o
  ) else $error("uncorrected codeword not pulsed");
  chk_fixed_cause: assert property (
    fixed_codeword_pulse_o |-> $past(cw_done_i) && $past(corr_on)
  ) else $error("corrected pulse without correction");
  chk_rx_aligned: assert property (
    rx_lanes_aligned_o |-> $past(rx_marker_lock_lane0_o) && $past(rx_marker_lock_lane1_o)
  ) else $error("aligned without both lane locks");
  chk_tx_lock: assert property (
    rstn_i |=> (tx_block_lock_o == $past(tx_block_lock_i))
  ) else $error("transmit lock not following");
endmodule // rs_fec_mode_control_status

// >>> bench/fec_decoder_stub.sv
// decoder result stub: hands one result per codeword to the status block
// assumes the bench calls send() from its main thread, right after an edge
// codeword boundaries rely on the pcs spacing its markers 20480 words apart
`timescale 1ns/10ps
module fec_decoder_stub (
  input  wire logic                          clock_i,
  output logic                               cw_done_o,  // one per codeword
  output logic                               cw_unc_o,   // codeword beyond repair
  output logic [rs_fec_pkg::SERR_W-1:0]      cw_errs_o   // symbol errors found
);
  initial begin
    cw_done_o = 1'b0;
    cw_unc_o  = 1'b1;
    cw_errs_o = 4'hF;
  end
  // back to back results; qualifiers are inverted on the edge done drops so the
  // block can never lean on a stale value
  task automatic send(input int n, input logic unc, input logic [3:0] errs);
    repeat (n) begin
      @(posedge clock_i);
      cw_done_o <= 1'b1;
      cw_unc_o  <= unc;
      cw_errs_o <= errs;
    end
    @(posedge clock_i);
    cw_done_o <= 1'b0;
    cw_unc_o  <= ~unc;
    cw_errs_o <= ~errs;
  endtask
endmodule // fec_decoder_stub

// >>> bench/rs_fec_mode_control_status_tb.sv
// self-checking bench for the fec mode control and status block
// assumes the decoder stub above and the design package are compiled first
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module rs_fec_mode_control_status_tb;
  import rs_fec_pkg::*;
  logic clock_i, rstn_i = 1'b0, fec_enable_i = 1'b0, correction_enable_i = 1'b0;
  logic indication_enable_i = 1'b0, ieee_mode_i = 1'b0, tx_block_lock_i = 1'b0;
  logic tx_frame_aligned_i = 1'b0, rx_lane0_lock_i = 1'b0, rx_lane1_lock_i = 1'b0;
  logic rx_deskew_done_i = 1'b0, tx_block_lock_o, tx_frame_aligned_o, irq_o;
  logic [63:0] pcs_tx_data_i = 64'hA5A5_0F0F_1234_5678, fec_tx_data_i = 64'h5A5A_F0F0_8765_4321;
  logic [63:0] serdes_tx_data_o;
  logic [6:0]  rx_lane0_cycles_i = 7'h00, rx_lane0_frac_i = 7'h00;
  logic [6:0]  rx_lane1_cycles_i = 7'h00, rx_lane1_frac_i = 7'h00;
  logic [13:0] rx_lane_fill0_o, rx_lane_fill1_o;
  logic rx_marker_lock_lane0_o, rx_marker_lock_lane1_o, rx_lanes_aligned_o;
  logic cw_done_i, cw_uncorrectable_i, fixed_codeword_pulse_o, unfixable_codeword_pulse_o;
  logic [3:0]  cw_symbol_errors_i, s_axi_wstrb = 4'hF;
  logic pcs_error_mark_o, high_symbol_error_out_o, fec_inserted_o, correction_on_o;
  logic indication_on_o, decoder_bypass_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  int n_fail = 0, checked = 0, cycles = 0;
  // rows {fec, corr, ind, ieee, inserted, dec bypass, corr on, ind on}; last row is ser mode
  logic [7:0] rows [5] = '{8'b10001100, 8'b01110000, 8'b11111011, 8'b10011000, 8'b11011010};
  rs_fec_mode_control_status i_rs_fec_mode_control_status (.*);
  fec_decoder_stub i_fec_decoder_stub (.clock_i(clock_i), .cw_done_o(cw_done_i),
    .cw_unc_o(cw_uncorrectable_i), .cw_errs_o(cw_symbol_errors_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // a hang is cut short here; two full error windows take about 16,400 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rd_d, rd_r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    foreach (rows[i]) begin
      @(posedge clock_i);
      {fec_enable_i, correction_enable_i, indication_enable_i, ieee_mode_i} <= rows[i][7:4];
      rstn_i <= 1'b0;
      @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      // controls turn over right after capture and must be ignored
      {fec_enable_i, correction_enable_i, indication_enable_i, ieee_mode_i} <= ~rows[i][7:4];
      repeat (2) @(posedge clock_i);
      #1 `CHK("inserted", rows[i][3], fec_inserted_o)
      `CHK("dec bypass", rows[i][2], decoder_bypass_o)
      `CHK("corr ind", rows[i][1:0], {correction_on_o, indication_on_o})
      `CHK("tx data", rows[i][7] ? fec_tx_data_i : pcs_tx_data_i, serdes_tx_data_o)
      // a word beyond repair: counted while decoding, marked only with indication on
      i_fec_decoder_stub.send(1, 1'b1, 4'h0);
      #1 `CHK("row unfix", rows[i][3] & ~rows[i][2], unfixable_codeword_pulse_o)
      `CHK("row mark", rows[i][0], pcs_error_mark_o)
    end
    $display("mode table done");
    i_fec_decoder_stub.send(1, 1'b1, 4'h0);
    #1 `CHK("unfixable", 1'b1, unfixable_codeword_pulse_o)
    `CHK("err mark", 1'b0, pcs_error_mark_o)
    i_fec_decoder_stub.send(1, 1'b0, 4'h3);
    #1 `CHK("fixed", 1'b1, fixed_codeword_pulse_o)
    `CHK("unfix pulse", 1'b0, unfixable_codeword_pulse_o)
    wr(IRQ_MASK_OFS, 32'h2);
    @(posedge clock_i);
    #1 `CHK("irq set", 1'b1, irq_o)
    wr(IRQ_STAT_OFS, 32'h2);
    @(posedge clock_i);
    #1 `CHK("irq clr", 1'b0, irq_o)
    rd(8'h40);
    `CHK("unmapped", RESP_SLVERR, rd_r)
    wr(MODE_OFS, 32'h0);
    `CHK("ro write", RESP_OKAY, wr_r)
    rd(MODE_OFS);
    `CHK("mode reg", 6'h2B, rd_d[5:0])
    $display("codeword and register tests done");
    // 3 + 103*4 + 2 = 417 errors: on the limit, not above it
    i_fec_decoder_stub.send(103, 1'b0, 4'h4);
    i_fec_decoder_stub.send(1, 1'b0, 4'h2);
    repeat (2) @(posedge clock_i);
    #1 `CHK("hi ser 417", 1'b0, high_symbol_error_out_o)
    i_fec_decoder_stub.send(1, 1'b0, 4'h1);
    repeat (2) @(posedge clock_i);
    #1 `CHK("hi ser 418", 1'b1, high_symbol_error_out_o)
    // 108 codewords so far: close this window, then a clean window drops the flag
    i_fec_decoder_stub.send(8084, 1'b0, 4'h0);
    i_fec_decoder_stub.send(8191, 1'b0, 4'h0);
    #1 `CHK("hi ser held", 1'b1, high_symbol_error_out_o)
    i_fec_decoder_stub.send(1, 1'b0, 4'h0);
    #1 `CHK("hi ser clean", 1'b0, high_symbol_error_out_o)
    @(posedge clock_i);
    {tx_block_lock_i, tx_frame_aligned_i, rx_lane0_lock_i, rx_lane1_lock_i} <= 4'hF;
    {rx_lane0_cycles_i, rx_lane0_frac_i, rx_deskew_done_i} <= {7'h05, 7'h41, 1'b1};
    {rx_lane1_cycles_i, rx_lane1_frac_i} <= {7'h7F, 7'h00};
    @(posedge clock_i);
    #1 `CHK("tx lock", 2'h3, {tx_block_lock_o, tx_frame_aligned_o})
    `CHK("lane locks", 2'h3, {rx_marker_lock_lane0_o, rx_marker_lock_lane1_o})
    `CHK("fill0", 14'h02C1, rx_lane_fill0_o)
    `CHK("fill1", 14'h3F80, rx_lane_fill1_o)
    @(posedge clock_i);
    #1 `CHK("aligned", 1'b1, rx_lanes_aligned_o)
    @(posedge clock_i);
    rx_lane1_lock_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1 `CHK("lane1 lost", 2'h2, {rx_marker_lock_lane0_o, rx_marker_lock_lane1_o})
    @(posedge clock_i);
    #1 `CHK("unaligned", 1'b0, rx_lanes_aligned_o)
    // high error rise, lane lock lost and alignment gained are all latched
    rd(IRQ_STAT_OFS);
    `CHK("irq events", 4'hD, rd_d[3:0])
    $display("error rate and status tests done");
    results();
  end
endmodule // rs_fec_mode_control_status_tb
